// File: include/lsf_defs.svh
// register indices, field positions, reset values for the limit status block
`ifndef LSF_DEFS_SVH
`define LSF_DEFS_SVH
// register indices; byte address is four times the index
`define LSF_IDX_CONFIG 8'h40
`define LSF_IDX_STAT_ONE 8'h41
`define LSF_IDX_STAT_TWO 8'h42
`define LSF_IDX_IRQ_STAT 8'h48
`define LSF_IDX_IRQ_MASK 8'h49
`define LSF_IDX_PIN_CFG 8'h4a
// configuration register fields
`define LSF_CFG_RUN 0
`define LSF_CFG_LOCK 1
`define LSF_CFG_READY 2
`define LSF_CFG_FULL 3
`define LSF_CFG_VX 4
`define LSF_CFG_SPINDIS 5
`define LSF_CFG_TODIS 6
`define LSF_CFG_RESET 8'h04
`define LSF_CFG_WMASK 8'h7b
`define LSF_CFG_LOCKED_MASK 8'h50
// status fields
`define LSF_ST_AGG 7
`define LSF_STAT_RESET 8'h00
`define LSF_MASK_RESET 8'h00
// pin configuration: bit 0 selects the thermal timer role for bit 0
`define LSF_PIN_THERMAL_LIMIT_PIN 0
`define LSF_PIN_RESET 8'h00
// ahb constants
`define LSF_HTRANS_NONSEQ 2'h2
`define LSF_HRESP_OKAY 1'h0
`define LSF_BYTE_ZERO 8'h00
`endif

// File: include/lsf_pkg.sv
// types shared by the limit status block
package lsf_pkg;
   typedef logic [7:0] lsf_byte_t;
   // kind of the pending ahb data phase
   typedef enum logic [1:0] {
      LSF_DP_IDLE,
      LSF_DP_READ,
      LSF_DP_WRITE
   } lsf_dp_e;
endpackage

// File: logic/lsf_limit_status.sv
// limit status flags with configuration and interrupt registers on ahb-lite
//
// Design decision made here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "lsf_defs.svh"

// How it works
// - bit0 latches 2.5 V limit fault
// - bit0 takes thermal timer in pin mode
// - bits1-3 latch core, supply, 5 V faults
// - bit4 latches remote one temperature fault
// - bit5 latches local temperature fault
// - bit6 latches remote two temperature fault
// - read clears flag only once fault gone
// - bit7 is OR of second register
// - first status register resets to zero
// - second status register resets to zero
// - monitor_run stays writable after lock
// - monitor off forces fans full duty
// - monitor_run selects programmed or default limits
// - lock makes lockable bits read-only
module lsf_limit_status
   import lsf_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [ADDR_W-1:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic volt25_fault,
   input wire logic thermal_timer_over,
   input wire logic core_voltage_fault,
   input wire logic supply_fault,
   input wire logic volt5_fault,
   input wire logic remote_one_temp_fault,
   input wire logic local_temp_fault,
   input wire logic remote_two_temp_fault,
   input wire logic [7:0] second_reg_fault,
   output logic monitor_run,
   output logic use_programmed_limits,
   output logic pwm_full_duty,
   output logic lock_active,
   output logic thermal_limit_pin_mode,
   output logic irq
);

   // ==========================================================
   // elaboration checks; word index needs haddr[9:2]
   if (ADDR_W < 10 || ADDR_W > 32) begin : g_addr_w_check
      $error("ADDR_W must lie between 10 and 32");
   end

   // ==========================================================
   // declarations
   lsf_byte_t status_one_r;
   lsf_byte_t status_two_r;
   lsf_byte_t config_r;
   lsf_byte_t pin_cfg_r;
   lsf_byte_t irq_stat_r;
   lsf_byte_t irq_mask_r;
   lsf_byte_t irq_stat_nxt;
   lsf_byte_t dp_idx_r;
   lsf_dp_e dp_kind_r;
   logic [31:0] hrdata_r;
   logic irq_r;
   logic pwm_full_r;
   logic [6:0] src_one;
   logic [7:0] irq_evt;
   logic take;
   logic rd_take;
   lsf_byte_t take_idx;
   logic clr_one;
   logic clr_two;
   logic wr_cfg;
   logic wr_pin;
   logic wr_irq_stat;
   logic wr_irq_mask;
   logic wr_stat_one;
   logic wr_stat_two;
   lsf_byte_t wbyte;

   // word index of a byte address
   function automatic lsf_byte_t word_idx(input logic [ADDR_W-1:0] a);
      word_idx = a[9:2];
   endfunction

   // ==========================================================
   // ahb address and data phase decode
   assign take = hsel && hready && (htrans == `LSF_HTRANS_NONSEQ);
   assign rd_take = take && !hwrite;
   assign take_idx = word_idx(haddr);
   assign wbyte = hwdata[7:0];
   assign wr_cfg = (dp_kind_r == LSF_DP_WRITE) && (dp_idx_r == `LSF_IDX_CONFIG);
   assign wr_pin = (dp_kind_r == LSF_DP_WRITE) && (dp_idx_r == `LSF_IDX_PIN_CFG);
   assign wr_irq_stat = (dp_kind_r == LSF_DP_WRITE) && (dp_idx_r == `LSF_IDX_IRQ_STAT);
   assign wr_irq_mask = (dp_kind_r == LSF_DP_WRITE) && (dp_idx_r == `LSF_IDX_IRQ_MASK);
   assign wr_stat_one = (dp_kind_r == LSF_DP_WRITE) && (dp_idx_r == `LSF_IDX_STAT_ONE);
   assign wr_stat_two = (dp_kind_r == LSF_DP_WRITE) && (dp_idx_r == `LSF_IDX_STAT_TWO);
   // the read clears at the address-phase edge; data phase returns the pre-clear value
   assign clr_one = rd_take && (take_idx == `LSF_IDX_STAT_ONE);
   assign clr_two = rd_take && (take_idx == `LSF_IDX_STAT_TWO);

   // data phase bookkeeping; slave never inserts wait states
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_kind_r <= LSF_DP_IDLE;
         dp_idx_r <= `LSF_BYTE_ZERO;
      end else if (hready) begin
         dp_kind_r <= !take ? LSF_DP_IDLE : (hwrite ? LSF_DP_WRITE : LSF_DP_READ);
         dp_idx_r <= take_idx;
      end
   end

   // read mux; unmapped words read as zero, answer always okay
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_r <= 32'h0000_0000;
      end else if (rd_take) begin
         hrdata_r <= 32'h0000_0000;
         unique case (take_idx)
            `LSF_IDX_CONFIG: hrdata_r[7:0] <= config_r;
            `LSF_IDX_STAT_ONE: hrdata_r[7:0] <= {|status_two_r, status_one_r[6:0]};
            `LSF_IDX_STAT_TWO: hrdata_r[7:0] <= status_two_r;
            `LSF_IDX_IRQ_STAT: hrdata_r[7:0] <= irq_stat_r;
            `LSF_IDX_IRQ_MASK: hrdata_r[7:0] <= irq_mask_r;
            `LSF_IDX_PIN_CFG: hrdata_r[7:0] <= pin_cfg_r;
            default: hrdata_r[7:0] <= `LSF_BYTE_ZERO;
         endcase
      end
   end

   // ==========================================================
   // fault sources of the first status register
   // bit0 source picked by pin role
   assign src_one[0] = pin_cfg_r[`LSF_PIN_THERMAL_LIMIT_PIN] ? thermal_timer_over : volt25_fault;
   assign src_one[3:1] = {volt5_fault, supply_fault, core_voltage_fault};
   assign src_one[6:4] = {remote_two_temp_fault, local_temp_fault, remote_one_temp_fault};

   // first status register; writes never reach it
   // no write path
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         status_one_r <= `LSF_STAT_RESET;
      end else if (clr_one) begin
         status_one_r <= {1'b0, src_one};
      end else begin
         status_one_r <= {1'b0, status_one_r[6:0] | src_one};
      end
   end

   // second status register, same read-to-clear behaviour
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         status_two_r <= `LSF_STAT_RESET;
      end else if (clr_two) begin
         status_two_r <= second_reg_fault;
      end else begin
         status_two_r <= status_two_r | second_reg_fault;
      end
   end

   // ==========================================================
   // configuration and pin role registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         config_r <= `LSF_CFG_RESET;
      end else if (wr_cfg) begin
         config_r[`LSF_CFG_RUN] <= wbyte[`LSF_CFG_RUN];
         config_r[`LSF_CFG_FULL] <= wbyte[`LSF_CFG_FULL];
         config_r[`LSF_CFG_SPINDIS] <= wbyte[`LSF_CFG_SPINDIS];
         // lock is write-once, guards lockable bits
         config_r[`LSF_CFG_LOCK] <= config_r[`LSF_CFG_LOCK] | wbyte[`LSF_CFG_LOCK];
         if (!config_r[`LSF_CFG_LOCK]) begin
            config_r[`LSF_CFG_VX] <= wbyte[`LSF_CFG_VX];
            config_r[`LSF_CFG_TODIS] <= wbyte[`LSF_CFG_TODIS];
         end
      end
   end

   // pin role is lockable too: a locked part cannot swap what bit0 reports
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_cfg_r <= `LSF_PIN_RESET;
      end else if (wr_pin && !config_r[`LSF_CFG_LOCK]) begin
         pin_cfg_r <= {7'h00, wbyte[`LSF_PIN_THERMAL_LIMIT_PIN]};
      end
   end

   // ==========================================================
   // interrupts: new latches are events, write one to clear, set wins
   assign irq_evt = {|(second_reg_fault & ~status_two_r), src_one & ~status_one_r[6:0]};
   always_comb begin
      irq_stat_nxt = irq_stat_r;
      if (wr_irq_stat) begin
         irq_stat_nxt = irq_stat_nxt & ~wbyte;
      end
      irq_stat_nxt = irq_stat_nxt | irq_evt;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_stat_r <= `LSF_STAT_RESET;
         irq_mask_r <= `LSF_MASK_RESET;
         irq_r <= 1'b0;
      end else begin
         irq_stat_r <= irq_stat_nxt;
         irq_r <= |(irq_stat_r & irq_mask_r);
         if (wr_irq_mask) begin
            irq_mask_r <= wbyte;
         end
      end
   end

   // ==========================================================
   // fan protection; full duty also when software asks for full speed
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pwm_full_r <= 1'b1;
      end else begin
         pwm_full_r <= !config_r[`LSF_CFG_RUN] || config_r[`LSF_CFG_FULL];
      end
   end

   // ==========================================================
   // outputs, all from flip-flops except hreadyout and hresp, which are tied to constants
   assign hrdata = hrdata_r;
   assign hreadyout = 1'b1;
   assign hresp = `LSF_HRESP_OKAY;
   assign monitor_run = config_r[`LSF_CFG_RUN];
   assign use_programmed_limits = config_r[`LSF_CFG_RUN];
   assign pwm_full_duty = pwm_full_r;
   assign lock_active = config_r[`LSF_CFG_LOCK];
   assign thermal_limit_pin_mode = pin_cfg_r[`LSF_PIN_THERMAL_LIMIT_PIN];
   assign irq = irq_r;

   // ==========================================================
   // assertions
   sequence s_rd_one;
      clr_one;
   endsequence
   sequence s_no_fault;
      src_one == 7'h00;
   endsequence

   property p_bit0_volt;
      @(posedge hclk) disable iff (!hresetn)
      volt25_fault && !pin_cfg_r[`LSF_PIN_THERMAL_LIMIT_PIN] |=> status_one_r[0];
   endproperty
   a_bit0_volt: assert property (p_bit0_volt) else $error("bit0 missed 2.5 V fault");

   property p_bit0_thermal_limit_pin;
      @(posedge hclk) disable iff (!hresetn)
      thermal_timer_over && pin_cfg_r[`LSF_PIN_THERMAL_LIMIT_PIN] |=> status_one_r[0];
   endproperty
   a_bit0_thermal_limit_pin: assert property (p_bit0_thermal_limit_pin) else $error("bit0 missed timer limit");

   property p_volt_flags;
      @(posedge hclk) disable iff (!hresetn)
      1'b1 |=> (status_one_r[3:1] & $past(src_one[3:1])) == $past(src_one[3:1]);
   endproperty
   a_volt_flags: assert property (p_volt_flags) else $error("voltage flag not latched");

   property p_remote_one;
      @(posedge hclk) disable iff (!hresetn)
      remote_one_temp_fault |=> status_one_r[4];
   endproperty
   a_remote_one: assert property (p_remote_one) else $error("remote one flag missed");

   property p_local;
      @(posedge hclk) disable iff (!hresetn)
      local_temp_fault |=> status_one_r[5];
   endproperty
   a_local: assert property (p_local) else $error("local flag missed");

   property p_remote_two;
      @(posedge hclk) disable iff (!hresetn)
      remote_two_temp_fault |=> status_one_r[6];
   endproperty
   a_remote_two: assert property (p_remote_two) else $error("remote two flag missed");

   property p_read_clear;
      @(posedge hclk) disable iff (!hresetn)
      s_rd_one and s_no_fault |=> status_one_r[6:0] == 7'h00;
   endproperty
   a_read_clear: assert property (p_read_clear) else $error("read did not clear subsided flags");

   property p_aggregate;
      @(posedge hclk) disable iff (!hresetn)
      s_rd_one |=> hrdata[`LSF_ST_AGG] == $past(|status_two_r);
   endproperty
   a_aggregate: assert property (p_aggregate) else $error("bit7 is not the second register OR");

   property p_hold;
      @(posedge hclk) disable iff (!hresetn)
      !clr_one |=> (status_one_r[6:0] & $past(status_one_r[6:0])) == $past(status_one_r[6:0]);
   endproperty
   a_hold: assert property (p_hold) else $error("flag dropped without read");

   property p_run_after_lock;
      @(posedge hclk) disable iff (!hresetn)
      wr_cfg && lock_active |=> monitor_run == $past(wbyte[`LSF_CFG_RUN]);
   endproperty
   a_run_after_lock: assert property (p_run_after_lock) else $error("run bit locked");

   property p_full_duty;
      @(posedge hclk) disable iff (!hresetn)
      !monitor_run ##1 !monitor_run |-> pwm_full_duty;
   endproperty
   a_full_duty: assert property (p_full_duty) else $error("fans not full while stopped");

   property p_locked;
      @(posedge hclk) disable iff (!hresetn)
      lock_active |=> lock_active && $stable(config_r[`LSF_CFG_VX]) && $stable(config_r[`LSF_CFG_TODIS]);
   endproperty
   a_locked: assert property (p_locked) else $error("lockable bit changed while locked");

   property p_status_write;
      @(posedge hclk) disable iff (!hresetn)
      wr_stat_one && src_one == 7'h00 && !clr_one |=> $stable(status_one_r);
   endproperty
   a_status_write: assert property (p_status_write) else $error("status write took effect");

   property p_two_write;
      @(posedge hclk) disable iff (!hresetn)
      wr_stat_two && second_reg_fault == 8'h00 && !clr_two |=> $stable(status_two_r);
   endproperty
   a_two_write: assert property (p_two_write) else $error("second status write took effect");

   property p_reset_zero;
      @(posedge hclk) disable iff (!hresetn)
      $rose(hresetn) |-> status_one_r == `LSF_STAT_RESET;
   endproperty
   a_reset_zero: assert property (p_reset_zero) else $error("status not zero after reset");

endmodule // lsf_limit_status
`default_nettype wire

// File: tb/lsf_host.sv
// ahb-lite single-transfer master standing in for the host
`timescale 1ns/1ps
`default_nettype none
module lsf_host (
   input wire logic hclk,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   output logic hsel,
   output logic [11:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata,
   output logic timed_out
);
   // ==========================================
   // idle bus at time zero
   initial begin
      hsel = 1'b0;
      haddr = 12'h000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h00000000;
      timed_out = 1'b0;
   end
   // ==========================================
   // one word transfer; each phase held until hready is seen high
   task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
      int n;
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= wr;
      htrans <= 2'h2;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hready !== 1'b1 && n < 50);
      htrans <= 2'h0;
      hwdata <= wd;
      do begin
         @(posedge hclk);
         n++;
      end while (hready !== 1'b1 && n < 100);
      // read data taken at the edge that ends the data phase
      rd = hrdata;
      if (n >= 50) timed_out = 1'b1;
   endtask
endmodule // lsf_host
`default_nettype wire

// File: tb/tb.sv
// self-checking bench for the limit status block
`timescale 1ns/1ps
`default_nettype none
`include "lsf_defs.svh"
module tb;
   localparam logic [11:0] A_CFG = {2'b00, `LSF_IDX_CONFIG, 2'b00};
   localparam logic [11:0] A_ST1 = {2'b00, `LSF_IDX_STAT_ONE, 2'b00};
   localparam logic [11:0] A_ST2 = {2'b00, `LSF_IDX_STAT_TWO, 2'b00};
   localparam logic [11:0] A_IST = {2'b00, `LSF_IDX_IRQ_STAT, 2'b00};
   localparam logic [11:0] A_MSK = {2'b00, `LSF_IDX_IRQ_MASK, 2'b00};
   localparam logic [11:0] A_PIN = {2'b00, `LSF_IDX_PIN_CFG, 2'b00};
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel, hwrite, hreadyout, hresp, timed_out;
   logic [11:0] haddr;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] hwdata, hrdata, rv;
   logic [6:0] flt = 7'h00;
   logic thr = 1'b0;
   logic [7:0] sec = 8'h00;
   logic monitor_run, use_programmed_limits, pwm_full_duty, lock_active, thermal_limit_pin_mode, irq;
   int mismatches = 0;
   int check_count = 0;

   // ==========================================
   // clock and instances
   always #10 hclk = ~hclk;
   lsf_host i_host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .timed_out(timed_out));
   lsf_limit_status i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .volt25_fault(flt[0]), .thermal_timer_over(thr),
      .core_voltage_fault(flt[1]), .supply_fault(flt[2]), .volt5_fault(flt[3]),
      .remote_one_temp_fault(flt[4]), .local_temp_fault(flt[5]), .remote_two_temp_fault(flt[6]),
      .second_reg_fault(sec), .monitor_run(monitor_run), .use_programmed_limits(use_programmed_limits),
      .pwm_full_duty(pwm_full_duty), .lock_active(lock_active),
      .thermal_limit_pin_mode(thermal_limit_pin_mode), .irq(irq));

   // ==========================================
   // helpers
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // a hung bus counts as a mismatch and ends the run
   task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      i_host.xfer(wr, a, wd, rv);
      if (timed_out) begin
         mismatches++;
         report_and_stop();
      end
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h00000000);
      chk(rv, exp);
   endtask
   // one-cycle fault pulse, low again before the next read is taken
   task automatic pulse(input logic [6:0] m, input logic t, input logic [7:0] s);
      flt <= m;
      thr <= t;
      sec <= s;
      @(posedge hclk);
      flt <= 7'h00;
      thr <= 1'b0;
      sec <= 8'h00;
      @(posedge hclk);
   endtask
   // outputs looked at mid-cycle so edge updates have landed
   task automatic look(input int n);
      repeat (n) @(negedge hclk);
   endtask

   // ==========================================
   // main sequence
   initial begin
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd(A_ST1, 32'h00);
      rd(A_ST2, 32'h00);
      rd(A_CFG, 32'h04);
      chk({31'h0, pwm_full_duty}, 32'h1);
      // each flag latches a short fault, then one read clears it
      for (int i = 0; i < 7; i++) begin
         pulse(7'h01 << i, 1'b0, 8'h00);
         rd(A_ST1, 32'h1 << i);
         rd(A_ST1, 32'h00);
      end
      // a fault still present survives the read
      flt <= 7'h08;
      repeat (2) @(posedge hclk);
      rd(A_ST1, 32'h08);
      rd(A_ST1, 32'h08);
      flt <= 7'h00;
      @(posedge hclk);
      rd(A_ST1, 32'h08);
      rd(A_ST1, 32'h00);
      // aggregate bit follows the second register
      pulse(7'h00, 1'b0, 8'h20);
      rd(A_ST1, 32'h80);
      rd(A_ST2, 32'h20);
      rd(A_ST2, 32'h00);
      rd(A_ST1, 32'h00);
      // writes to status registers change nothing
      pulse(7'h10, 1'b0, 8'h00);
      xfer(1'b1, A_ST1, 32'h00);
      xfer(1'b1, A_ST2, 32'hff);
      chk({31'h0, hresp}, 32'h0);
      rd(A_ST1, 32'h10);
      rd(A_ST2, 32'h00);
      rd(A_ST1, 32'h00);
      // thermal timer role for bit 0
      xfer(1'b1, A_PIN, 32'h01);
      look(1);
      chk({31'h0, thermal_limit_pin_mode}, 32'h1);
      @(posedge hclk);
      pulse(7'h01, 1'b0, 8'h00);
      rd(A_ST1, 32'h00);
      pulse(7'h00, 1'b1, 8'h00);
      rd(A_ST1, 32'h01);
      rd(A_ST1, 32'h00);
      xfer(1'b1, A_PIN, 32'h00);
      // interrupt raised, cleared, then masked
      xfer(1'b1, A_IST, 32'hff);
      xfer(1'b1, A_MSK, 32'h02);
      pulse(7'h02, 1'b0, 8'h00);
      look(2);
      chk({31'h0, irq}, 32'h1);
      @(posedge hclk);
      rd(A_IST, 32'h02);
      xfer(1'b1, A_IST, 32'h02);
      look(2);
      chk({31'h0, irq}, 32'h0);
      @(posedge hclk);
      rd(A_ST1, 32'h02);
      pulse(7'h04, 1'b0, 8'h00);
      look(2);
      chk({31'h0, irq}, 32'h0);
      @(posedge hclk);
      rd(A_IST, 32'h04);
      rd(12'h1fc, 32'h00);
      // run, lock and fan fallback
      xfer(1'b1, A_CFG, 32'h01);
      look(2);
      chk({30'h0, monitor_run, use_programmed_limits}, 32'h3);
      chk({31'h0, pwm_full_duty}, 32'h0);
      @(posedge hclk);
      xfer(1'b1, A_CFG, 32'h53);
      rd(A_CFG, 32'h57);
      chk({31'h0, lock_active}, 32'h1);
      xfer(1'b1, A_CFG, 32'h00);
      rd(A_CFG, 32'h56);
      look(2);
      chk({31'h0, pwm_full_duty}, 32'h1);
      chk({30'h0, monitor_run, use_programmed_limits}, 32'h0);
      @(posedge hclk);
      xfer(1'b1, A_PIN, 32'h01);
      rd(A_PIN, 32'h00);
      // a second power-on clears latched flags and releases the lock
      pulse(7'h01, 1'b0, 8'h01);
      hresetn <= 1'b0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd(A_ST1, 32'h00);
      rd(A_ST2, 32'h00);
      rd(A_CFG, 32'h04);
      chk({31'h0, lock_active}, 32'h0);
      report_and_stop();
   end
endmodule // tb
`default_nettype wire
